// ---- design/bblcr_pkg.sv ----
// Package for the converter and linear-regulator configuration registers
`default_nettype none
package bblcr_pkg;
    // Register offsets
    localparam logic [7:0] BBLCR_ADDR_WRITE_EN = 8'h01;
    localparam logic [7:0] BBLCR_ADDR_CONV_CFG = 8'h03;
    localparam logic [7:0] BBLCR_ADDR_LINREG = 8'h04;
    // Field positions
    localparam int BBLCR_BIT_WRITE_EN = 7;
    localparam int BBLCR_BIT_HOLD = 7;
    localparam int BBLCR_BIT_FIXED_PWM = 6;
    localparam int BBLCR_BIT_UV_BYPASS = 5;
    localparam int BBLCR_BIT_REF_EARLY = 5;
    localparam int BBLCR_LEVEL_MSB = 4;
    // Reset values
    localparam logic BBLCR_RST_HOLD = 1'h0;
    localparam logic BBLCR_RST_FIXED_PWM = 1'h0;
    localparam logic BBLCR_RST_UV_BYPASS = 1'h1;
    localparam logic [4:0] BBLCR_RST_CONV_LEVEL = 5'h13;
    localparam logic [4:0] BBLCR_RST_LINREG_LEVEL = 5'h12;
    localparam logic BBLCR_RST_REF_EARLY = 1'h0;
    localparam logic BBLCR_RST_WRITE_EN = 1'h0;
    // Highest converter level code in use
    localparam logic [4:0] BBLCR_CONV_LEVEL_MAX = 5'h1C;
endpackage : bblcr_pkg
`default_nettype wire

// ---- design/bblcr_regs.sv ----
// Converter and linear-regulator configuration register bank
`default_nettype none
module bblcr_regs
    import bblcr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register access port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Non-volatile preset load
    input wire logic preset_load,
    input wire logic [7:0] preset_conv_cfg,
    input wire logic [4:0] preset_linreg_level,
    // Analog status
    input wire logic conv_disable,
    input wire logic conv_out_below_in,
    input wire logic undervoltage_detect,
    // Analog controls
    output logic max_rail_switch,
    output logic converter_fixed_pwm,
    output logic converter_shutdown_uv,
    output logic undervoltage_int,
    output logic [4:0] converter_level_code,
    output logic [4:0] linreg_level_code,
    output logic reference_early_on
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic write_en_reg;
    logic hold_reg;
    logic fixed_pwm_reg;
    logic uv_bypass_reg;
    logic [4:0] conv_level_reg;
    logic [4:0] linreg_level_reg;
    logic ref_early_reg;
    logic switch_reg;
    logic switch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic write_en_next;
    logic hold_next;
    logic fixed_pwm_next;
    logic uv_bypass_next;
    logic [4:0] conv_level_next;
    logic [4:0] linreg_level_next;
    logic ref_early_next;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire logic hit_we = reg_addr == BBLCR_ADDR_WRITE_EN;
    wire logic hit_conv = reg_addr == BBLCR_ADDR_CONV_CFG;
    wire logic hit_lin = reg_addr == BBLCR_ADDR_LINREG;
    wire logic wr_we = reg_wr && hit_we;
    // Locked bank refuses writes and reads except at the write-enable register
    wire logic wr_conv = reg_wr && hit_conv && write_en_reg;
    wire logic wr_lin = reg_wr && hit_lin && write_en_reg;
    // Reserved codes are stored as written; analog side must not be given them
    wire logic level_reserved = conv_level_reg > BBLCR_CONV_LEVEL_MAX;
    wire logic [7:0] conv_view = {hold_reg, fixed_pwm_reg, uv_bypass_reg, conv_level_reg};
    wire logic [7:0] lin_view = {2'h0, ref_early_reg, linreg_level_reg};

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            rdata_next = 8'h00;
            if (hit_we) begin
                rdata_next = {write_en_reg, 7'h00};
            end else if (hit_conv && write_en_reg) begin
                rdata_next = conv_view;
            end else if (hit_lin && write_en_reg) begin
                rdata_next = lin_view;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Max-rail switch: held closed on disable only while hold set and output not below input
    always_comb begin
        switch_next = switch_reg;
        if (!conv_disable) begin
            switch_next = 1'h1;
        end else if (!hold_reg || conv_out_below_in) begin
            switch_next = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next values; presets win over a host write in the same cycle
    assign write_en_next = wr_we ? reg_wdata[BBLCR_BIT_WRITE_EN] : write_en_reg;

    // Converter bits
    assign hold_next = preset_load ? preset_conv_cfg[BBLCR_BIT_HOLD] :
        wr_conv ? reg_wdata[BBLCR_BIT_HOLD] : hold_reg;

    assign fixed_pwm_next = preset_load ? preset_conv_cfg[BBLCR_BIT_FIXED_PWM] :
        wr_conv ? reg_wdata[BBLCR_BIT_FIXED_PWM] : fixed_pwm_reg;

    assign uv_bypass_next = preset_load ? preset_conv_cfg[BBLCR_BIT_UV_BYPASS] :
        wr_conv ? reg_wdata[BBLCR_BIT_UV_BYPASS] : uv_bypass_reg;

    // Level codes
    assign conv_level_next = preset_load ? preset_conv_cfg[BBLCR_LEVEL_MSB:0] :
        wr_conv ? reg_wdata[BBLCR_LEVEL_MSB:0] : conv_level_reg;

    assign linreg_level_next = preset_load ? preset_linreg_level :
        wr_lin ? reg_wdata[BBLCR_LEVEL_MSB:0] : linreg_level_reg;

    // Reference bit has no preset; only the host changes it
    assign ref_early_next = wr_lin ? reg_wdata[BBLCR_BIT_REF_EARLY] : ref_early_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    // Lock bit
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            write_en_reg <= BBLCR_RST_WRITE_EN;
        end else begin
            write_en_reg <= write_en_next;
        end
    end

    // Hold bit
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hold_reg <= BBLCR_RST_HOLD;
        end else begin
            hold_reg <= hold_next;
        end
    end

    // Forced PWM
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fixed_pwm_reg <= BBLCR_RST_FIXED_PWM;
        end else begin
            fixed_pwm_reg <= fixed_pwm_next;
        end
    end

    // Undervoltage bypass
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            uv_bypass_reg <= BBLCR_RST_UV_BYPASS;
        end else begin
            uv_bypass_reg <= uv_bypass_next;
        end
    end

    // Converter level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conv_level_reg <= BBLCR_RST_CONV_LEVEL;
        end else begin
            conv_level_reg <= conv_level_next;
        end
    end

    // Linear-regulator level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            linreg_level_reg <= BBLCR_RST_LINREG_LEVEL;
        end else begin
            linreg_level_reg <= linreg_level_next;
        end
    end

    // Early reference
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ref_early_reg <= BBLCR_RST_REF_EARLY;
        end else begin
            ref_early_reg <= ref_early_next;
        end
    end

    // Switch opens in reset; it closes on the first clock edge with conv_disable low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            switch_reg <= 1'h0;
        end else begin
            switch_reg <= switch_next;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = rdata_reg;
    assign max_rail_switch = switch_reg;
    assign converter_fixed_pwm = fixed_pwm_reg;
    assign converter_shutdown_uv = undervoltage_detect && !uv_bypass_reg;
    assign undervoltage_int = undervoltage_detect;
    // Reserved code falls back to the reset level
    assign converter_level_code = level_reserved ? BBLCR_RST_CONV_LEVEL : conv_level_reg;
    assign linreg_level_code = linreg_level_reg;
    assign reference_early_on = ref_early_reg;

endmodule : bblcr_regs
`default_nettype wire

// ---- bench/bblcr_checker.sv ----
// Concurrent checks on the register bank ports
`default_nettype none
module bblcr_checker (
    // Inputs seen by the bank, plus the read data it drives
    input wire logic core_clk, nrst, reg_wr, reg_rd, preset_load, undervoltage_detect,
    input wire logic conv_disable, conv_out_below_in,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [4:0] preset_linreg_level,
    // Outputs driven by the bank
    input wire logic max_rail_switch, converter_fixed_pwm, undervoltage_int, reference_early_on,
    input wire logic [4:0] converter_level_code, linreg_level_code
);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic we_reg;
    wire logic wr_ok = reg_wr && we_reg && !preset_load;
    wire logic wd_ref = reg_wdata[5], wd_pwm = reg_wdata[6];
    wire logic [4:0] wd_lvl = reg_wdata[4:0];
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) we_reg <= 1'b0;
        else if (reg_wr && reg_addr == 8'h01) we_reg <= reg_wdata[7];
    end
    uv_int_a: assert property (undervoltage_int == undervoltage_detect) else $error("uv int");
    code_range_a: assert property (converter_level_code <= 5'h1C) else $error("code");
    drop_open_a: assert property (max_rail_switch && conv_disable && conv_out_below_in
        |=> !max_rail_switch) else $error("switch");
    lock_read_a: assert property (reg_rd && reg_addr == 8'h03 && !we_reg
        |=> reg_rdata == 8'h00) else $error("lock");
    rsvd_zero_a: assert property (reg_rd && reg_addr == 8'h04
        |=> reg_rdata[7:6] == 2'h0) else $error("rsvd");
    linreg_wr_a: assert property (wr_ok && reg_addr == 8'h04
        |=> linreg_level_code == $past(wd_lvl)) else $error("linreg");
    ref_wr_a: assert property (wr_ok && reg_addr == 8'h04
        |=> reference_early_on == $past(wd_ref)) else $error("ref");
    pwm_wr_a: assert property (wr_ok && reg_addr == 8'h03
        |=> converter_fixed_pwm == $past(wd_pwm)) else $error("pwm");
    preset_a: assert property (preset_load
        |=> linreg_level_code == $past(preset_linreg_level)) else $error("preset");
    cover property (preset_load);
    cover property (wr_ok && reg_addr == 8'h04);
    cover property (max_rail_switch && conv_disable ##1 !max_rail_switch);
endmodule : bblcr_checker
bind bblcr_regs bblcr_checker i_bblcr_checker (.*);
`default_nettype wire

// ---- bench/bblcr_host.sv ----
// Host model driving the register access strobes
`default_nettype none
module bblcr_host (
    input wire logic core_clk,
    output logic reg_wr, reg_rd,
    output logic [7:0] reg_addr, reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns; timeprecision 1ns;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    task automatic wr(input logic [7:0] a, d);
        @(negedge core_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge core_clk);
        // Released bus shows no stale value
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(negedge core_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge core_clk);
        {reg_rd, reg_addr} = {1'b0, ~a};
        r = reg_rdata;
    endtask : rd
    task automatic unlock;
        wr(8'h01, 8'h80);
    endtask : unlock
endmodule : bblcr_host
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the register bank
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
    timeunit 1ns; timeprecision 1ns;
    logic core_clk = 0, nrst = 0, preset_load = 0, conv_disable = 1, conv_out_below_in = 0;
    logic undervoltage_detect = 0, reg_wr, reg_rd, max_rail_switch, converter_fixed_pwm;
    logic converter_shutdown_uv, undervoltage_int, reference_early_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, preset_conv_cfg = 8'h80, r;
    logic [4:0] preset_linreg_level = 5'h05, converter_level_code, linreg_level_code;
    logic [31:0] rows [6] = '{32'h03454565, 32'h03DCDC7C, 32'h03FDFD33,
        32'h04FF3F3F, 32'h04121212, 32'h07FF0012};
    int bad_count = 0, n_checks = 0;
    wire logic [5:0] conv_view = {converter_fixed_pwm, converter_level_code};
    wire logic [5:0] lin_view = {reference_early_on, linreg_level_code};
    always #5 core_clk = ~core_clk;
    bblcr_regs i_bblcr_regs (.*);
    bblcr_host i_bblcr_host (.*);
    task automatic stop_test;
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #5000 bad_count++;
        stop_test();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        nrst = 1;
        `CHK({max_rail_switch, conv_view, lin_view}, 13'h04D2)
        i_bblcr_host.rd(8'h03, r);
        `CHK(r, 8'h00)
        i_bblcr_host.unlock();
        i_bblcr_host.rd(8'h03, r);
        `CHK(r, 8'h33)
        undervoltage_detect = 1;
        foreach (rows[i]) begin
            i_bblcr_host.wr(rows[i][31:24], rows[i][23:16]);
            i_bblcr_host.rd(rows[i][31:24], r);
            `CHK(r, rows[i][15:8])
            `CHK({converter_shutdown_uv, rows[i][26] ? lin_view : conv_view}, rows[i][6:0])
        end
        // Hold set by last converter write: switch waits for the output to drop
        conv_disable = 0;
        @(negedge core_clk);
        conv_disable = 1;
        repeat (2) @(negedge core_clk);
        `CHK(max_rail_switch, 1'b1)
        conv_out_below_in = 1;
        @(negedge core_clk);
        `CHK({max_rail_switch, undervoltage_int}, 2'b01)
        i_bblcr_host.wr(8'h03, 8'h00);
        {conv_out_below_in, conv_disable} = 2'b00;
        @(negedge core_clk);
        conv_disable = 1;
        @(negedge core_clk);
        `CHK(max_rail_switch, 1'b0)
        preset_load = 1;
        @(negedge core_clk);
        preset_load = 0;
        `CHK({conv_view, lin_view}, 12'h005)
        i_bblcr_host.wr(8'h01, 8'h00);
        i_bblcr_host.wr(8'h04, 8'h3F);
        i_bblcr_host.rd(8'h04, r);
        `CHK({r, lin_view}, 14'h0005)
        // Mid-run reset drops presets back to fixed defaults
        nrst = 0;
        @(negedge core_clk);
        nrst = 1;
        `CHK({max_rail_switch, conv_view, lin_view}, 13'h04D2)
        i_bblcr_host.rd(8'h03, r);
        `CHK(r, 8'h00)
        stop_test();
    end
endmodule : testbench
`default_nettype wire
